// file: logic/icc_capture.sv
`timescale 1ns/10ps
`include "icc_defs.svh"
module icc_capture #(
	parameter int CNT_W = 16
) (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] chan_pin_in,
	input wire logic lowspeed_osc_div_signal_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic capture_irq_out
);
	// ----------------------------------------
	// State.
	// ----------------------------------------
	// All registers of the block live in this one struct.
	typedef struct packed {
		logic [1:0][3:0] pin_sync;
		logic osc_s1;
		logic osc_s2;
		logic [3:0] pin_prev;
		logic osc_prev;
		logic [7:0] capture_io_control_ab;
		logic [7:0] capture_io_control_cd;
		logic [7:0] timer_mode_reg;
		logic [CNT_W-1:0] up_counter;
		logic [3:0][CNT_W-1:0] general_reg;
		logic [4:0] event_flags;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
	} icc_state_s;

	icc_state_s state;
	icc_state_s next_state;

	// ----------------------------------------
	// Edge decoding.
	// ----------------------------------------
	// The reserved code never reports an edge.
	function automatic logic edge_hit(input logic [1:0] sel, input logic cur,
		input logic prev);
		logic rise;
		logic fall;
		rise = cur & ~prev;
		fall = ~cur & prev;
		unique case (icc_pkg::icc_edge_e'(sel))
			icc_pkg::ICC_RISE: edge_hit = rise;
			icc_pkg::ICC_FALL: edge_hit = fall;
			icc_pkg::ICC_BOTH: edge_hit = rise | fall;
			icc_pkg::ICC_RSVD: edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	// ----------------------------------------
	// Next state.
	// ----------------------------------------
	always_comb begin
		logic [3:0] pin_now;
		logic [3:0] pin_old;
		logic [3:0] hit;
		logic buf_c;
		logic buf_d;
		logic wr;
		logic rd;
		logic ovf;
		logic [CNT_W:0] inc;
		next_state = state;
		pin_now = state.pin_sync[1];
		pin_old = state.pin_prev;
		hit = 4'h0;
		buf_c = state.timer_mode_reg[`ICC_BIT_BUF_C];
		buf_d = state.timer_mode_reg[`ICC_BIT_BUF_D];
		wr = psel_in & penable_in & pwrite_in & ~state.pready;
		rd = psel_in & penable_in & ~pwrite_in & ~state.pready;
		ovf = 1'b0;
		inc = {1'b0, state.up_counter} + {{CNT_W{1'b0}}, 1'b1};
		// ----------------------------------------
		// Synchronisers.
		// ----------------------------------------
		// Pins and oscillator pass two flip-flops before edge detection.
		next_state.pin_sync[0] = chan_pin_in;
		next_state.pin_sync[1] = state.pin_sync[0];
		next_state.osc_s1 = lowspeed_osc_div_signal_in;
		next_state.osc_s2 = state.osc_s1;
		next_state.pin_prev = pin_now;
		next_state.osc_prev = state.osc_s2;
		// ----------------------------------------
		// Counter.
		// ----------------------------------------
		// count or hold
		if (state.timer_mode_reg[`ICC_BIT_START]) begin
			next_state.up_counter = inc[CNT_W-1:0];
			ovf = inc[CNT_W];
		end
		// ----------------------------------------
		// Capture.
		// ----------------------------------------
		// channel A trigger source
		if (state.capture_io_control_ab[`ICC_BIT_A_MODE]) begin
			if (state.capture_io_control_ab[`ICC_BIT_A_TRIG])
				hit[0] = edge_hit(state.capture_io_control_ab[1:0],
					pin_now[0], pin_old[0]);
			else
				hit[0] = edge_hit(state.capture_io_control_ab[1:0],
					state.osc_s2, state.osc_prev);
		end
		hit[1] = state.capture_io_control_ab[`ICC_BIT_B_MODE] &
			edge_hit(state.capture_io_control_ab[5:4], pin_now[1], pin_old[1]);
		if (!buf_c)
			hit[2] = edge_hit(state.capture_io_control_cd[1:0],
				pin_now[2], pin_old[2]);
		if (!buf_d)
			hit[3] = edge_hit(state.capture_io_control_cd[5:4],
				pin_now[3], pin_old[3]);
		for (int i = 0; i < 4; i++) begin
			if (hit[i])
				next_state.general_reg[i] = state.up_counter;
		end
		// buffer transfer from A and B
		if (buf_c && hit[0])
			next_state.general_reg[2] = state.general_reg[0];
		if (buf_d && hit[1])
			next_state.general_reg[3] = state.general_reg[1];
		// ----------------------------------------
		// Register port.
		// ----------------------------------------
		// Every access is answered one cycle after its access phase starts.
		next_state.pready = psel_in & penable_in & ~state.pready;
		next_state.pslverr = 1'b0;
		next_state.prdata = 32'h0000_0000;
		if (wr) begin
			unique case (paddr_in)
				`ICC_OFF_IOCTL_AB: begin
					next_state.capture_io_control_ab = {1'b1, pwdata_in[6:0]};
				end
				`ICC_OFF_IOCTL_CD: next_state.capture_io_control_cd = pwdata_in[7:0];
				`ICC_OFF_MODE: next_state.timer_mode_reg = pwdata_in[7:0];
				`ICC_OFF_COUNTER: next_state.up_counter = pwdata_in[CNT_W-1:0];
				`ICC_OFF_STATUS: next_state.event_flags =
					state.event_flags & ~pwdata_in[4:0];
				`ICC_OFF_GEN_A: next_state.general_reg[0] = pwdata_in[CNT_W-1:0];
				`ICC_OFF_GEN_B: next_state.general_reg[1] = pwdata_in[CNT_W-1:0];
				`ICC_OFF_GEN_C: next_state.general_reg[2] = pwdata_in[CNT_W-1:0];
				`ICC_OFF_GEN_D: next_state.general_reg[3] = pwdata_in[CNT_W-1:0];
				default: next_state.pslverr = 1'b1;
			endcase
		end
		if (rd) begin
			unique case (paddr_in)
				`ICC_OFF_IOCTL_AB: next_state.prdata = {24'h00_0000,
					1'b1, state.capture_io_control_ab[6:0]};
				`ICC_OFF_IOCTL_CD: next_state.prdata = {24'h00_0000,
					state.capture_io_control_cd};
				`ICC_OFF_MODE: next_state.prdata = {24'h00_0000,
					state.timer_mode_reg};
				`ICC_OFF_COUNTER: next_state.prdata = 32'(state.up_counter);
				`ICC_OFF_STATUS: next_state.prdata = 32'(state.event_flags);
				`ICC_OFF_GEN_A: next_state.prdata = 32'(state.general_reg[0]);
				`ICC_OFF_GEN_B: next_state.prdata = 32'(state.general_reg[1]);
				`ICC_OFF_GEN_C: next_state.prdata = 32'(state.general_reg[2]);
				`ICC_OFF_GEN_D: next_state.prdata = 32'(state.general_reg[3]);
				default: next_state.pslverr = 1'b1;
			endcase
		end
		// ----------------------------------------
		// Events.
		// ----------------------------------------
		// A new event wins over a clear in the same cycle.
		// capture and overflow events
		next_state.event_flags = next_state.event_flags | {ovf, hit};
		next_state.irq = |next_state.event_flags;
	end

	// ----------------------------------------
	// State register.
	// ----------------------------------------
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state <= '0;
			state.capture_io_control_ab <= `ICC_RST_IOCTL_AB;
			state.capture_io_control_cd <= `ICC_RST_IOCTL_CD;
			state.timer_mode_reg <= `ICC_RST_MODE;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// Outputs.
	// ----------------------------------------
	// Every output comes straight from the state register.
	assign prdata_out = state.prdata;
	assign pready_out = state.pready;
	assign pslverr_out = state.pslverr;
	assign capture_irq_out = state.irq;
endmodule : icc_capture

// file: logic/icc_defs.svh
`ifndef ICC_DEFS_SVH
`define ICC_DEFS_SVH
`define ICC_IDX_IOCTL_AB 12'h124
`define ICC_IDX_IOCTL_CD 12'h125
`define ICC_OFF_IOCTL_AB 12'h490
`define ICC_OFF_IOCTL_CD 12'h494
`define ICC_OFF_GEN_A 12'h000
`define ICC_OFF_GEN_B 12'h004
`define ICC_OFF_GEN_C 12'h008
`define ICC_OFF_GEN_D 12'h00C
`define ICC_OFF_COUNTER 12'h010
`define ICC_OFF_MODE 12'h014
`define ICC_OFF_STATUS 12'h018
`define ICC_RST_IOCTL_AB 8'h88
`define ICC_RST_IOCTL_CD 8'h88
`define ICC_RST_MODE 8'h00
`define ICC_BIT_AB_UNUSED 7
`define ICC_BIT_A_TRIG 3
`define ICC_BIT_A_MODE 2
`define ICC_BIT_B_MODE 6
`define ICC_BIT_START 0
`define ICC_BIT_BUF_C 1
`define ICC_BIT_BUF_D 2
`define ICC_BIT_IRQ 4
`endif

// file: logic/icc_pkg.sv
package icc_pkg;
	typedef enum logic [1:0] {
		ICC_RISE,
		ICC_FALL,
		ICC_BOTH,
		ICC_RSVD
	} icc_edge_e;
endpackage : icc_pkg

// file: sim/four_channel_input_capture_ctrl_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin num_errors++; \
$display("unexpected %s exp %h got %h", n, e, s); end end
// ----
// Bench with register and capture model.
// ----
module four_channel_input_capture_ctrl_tb;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, osc = 0, rdy, slv, irq;
	logic [11:0] pa = 0;
	logic [31:0] pd = 0, rd, prd, ab = 8'h88, cd = 8'h88, v;
	logic [31:0] model [4];
	logic [3:0] pin = 0, e;
	logic err;
	int num_errors = 0, num_checks = 0;
	icc_capture uut (.core_clk_in(clk), .sys_rst_in(rst), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pw), .paddr_in(pa), .pwdata_in(pd),
		.chan_pin_in(pin), .lowspeed_osc_div_signal_in(osc),
		.prdata_out(prd), .pready_out(rdy), .pslverr_out(slv),
		.capture_irq_out(irq));
	initial forever #2.5 clk = ~clk;
	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pw <= w;
		pa <= a;
		pd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 20);
		if (rdy !== 1'b1) begin
			num_errors++;
			complete_run;
		end
		rd = prd;
		err = slv;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic pulse_pins;
		pin <= 4'h0;
		repeat (8) @(posedge clk);
		pin <= 4'hF;
		repeat (8) @(posedge clk);
	endtask : pulse_pins
	task automatic settle_read;
		repeat (8) @(posedge clk);
		apb(0, 12'h018, 0);
	endtask : settle_read
	initial begin
		void'($urandom(57));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 6; i++) begin
			if (i > 1) begin
				ab = $urandom & 8'hFF;
				cd = $urandom & 8'hFF;
				apb(1, 12'h490, ab);
				apb(1, 12'h494, cd);
			end
			apb(0, 12'h490, 0);
			`CHK("ab", ab | 8'h80, rd)
			apb(0, 12'h494, 0);
			`CHK("cd", cd, rd)
		end
		apb(0, 12'h0FC, 0);
		`CHK("refused", 1'b1, err)
		$display("registers done");
		apb(1, 12'h014, 1);
		for (int c = 0; c < 4; c++) begin
			apb(1, 12'h490, 8'h4C | c << 4 | c);
			apb(1, 12'h494, 8'hCC | c << 4 | c);
			for (int p = 0; p < 2; p++) begin
				apb(1, 12'h018, 8'h1F);
				pin <= p ? 4'h0 : 4'hF;
				settle_read;
				e = (c == 2 || c == p) ? 4'hF : 4'h0;
				`CHK("flags", e, rd[3:0])
				`CHK("irq", e != 0, irq)
			end
		end
		$display("edges done");
		apb(1, 12'h490, 8'h44);
		apb(1, 12'h018, 8'h1F);
		pin <= 4'h1;
		settle_read;
		`CHK("pin ignored", 1'b0, rd[0])
		osc <= 1'b1;
		settle_read;
		`CHK("osc", 1'b1, rd[0])
		$display("trigger done");
		apb(1, 12'h014, 0);
		v = $urandom & 32'h0000_FFFF;
		apb(1, 12'h010, v);
		apb(1, 12'h490, 8'h4C);
		apb(1, 12'h494, 8'hCC);
		pulse_pins;
		for (int k = 0; k < 4; k++) model[k] = v;
		apb(0, 12'h010, 0);
		`CHK("held count", v, rd)
		for (int k = 0; k < 4; k++) begin
			apb(0, 12'(4 * k), 0);
			`CHK("general", model[k], rd)
		end
		$display("values done");
		apb(1, 12'h014, 32'h0000_0006);
		v = $urandom & 32'h0000_FFFF;
		apb(1, 12'h010, v);
		pulse_pins;
		model[2] = model[0];
		model[3] = model[1];
		model[0] = v;
		model[1] = v;
		for (int k = 0; k < 4; k++) begin
			apb(0, 12'(4 * k), 0);
			`CHK("buffered", model[k], rd)
		end
		$display("buffer done");
		complete_run;
	end
endmodule : four_channel_input_capture_ctrl_tb

// file: sim/icc_capture_asserts.sv
`timescale 1ns/10ps
// ----
// Register port checks.
// ----
module icc_capture_asserts (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic capture_irq_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	logic mapped;
	assign mapped = paddr_in inside {12'h000, 12'h004, 12'h008, 12'h00C,
		12'h010, 12'h014, 12'h018, 12'h490, 12'h494};
	sequence wait_s;
		psel_in && penable_in && !pready_out;
	endsequence
	sequence rd_s;
		pready_out && !pwrite_in;
	endsequence
	answer_time_a: assert property (wait_s |=> pready_out)
		else $error("no answer after access edge");
	pulse_once_a: assert property (pready_out |=> !pready_out)
		else $error("ready held too long");
	answer_cause_a: assert property (pready_out |-> $past(penable_in))
		else $error("ready without access");
	err_ready_a: assert property (pslverr_out |-> pready_out)
		else $error("error without ready");
	unmapped_err_a: assert property (pready_out |-> pslverr_out == !mapped)
		else $error("error flag wrong for address");
	err_zero_a: assert property (rd_s and pslverr_out |-> prdata_out == 0)
		else $error("refused read data not zero");
	unused_bit_a: assert property (
		rd_s and paddr_in == 12'h490 |-> prdata_out[7])
		else $error("unused bit reads zero");
	byte_upper_a: assert property (rd_s and paddr_in[10]
		|-> prdata_out[31:8] == 0) else $error("upper bits set");
	irq_level_a: assert property (
		rd_s and paddr_in == 12'h018 and prdata_out[4:0] != 0
		|-> capture_irq_out) else $error("flag set without request");
endmodule : icc_capture_asserts
bind icc_capture icc_capture_asserts chk (.*);
